// *** core/page_register_file.sv ***
// page register file, accessed/written tracking and address relocation
//
// Function
// [RULE1] internal register index comes from virtual bits 4..1
// [RULE2] memory reference index low bits come from virtual bits 15..13
// [RULE3] memory reference top index bit is 0 for instruction, 1 for data
// [RULE4] top index bit source chosen per mode by data space enable
// [RULE5] base register written only on word or byte output with decode
// [RULE6] cycle terminate suppresses every software register write
// [RULE7] word output enables both lanes; byte output lane chosen by bit 0
// [RULE8] base register takes write data 11..0 at pause T4
// [RULE9] one mode's base set drives the base; read as bits 11..0
// [RULE10] descriptor holds length, accessed, written, direction, access control
// [RULE11] descriptor set selected by descriptor, paired base or mode selection
// [RULE12] descriptor writes load bits 15..8 and 3..0 like base writes
// [RULE13] tracking bits written on translation or on register write
// [RULE14] accessed bit set on a trap condition for that page
// [RULE15] written bit set by a write cycle to that page
// [RULE16] tracking bits captured at bust T5, written back at pause T4
// [RULE17] new tracking indications are ORed into stored bits
// [RULE18] no tracking set on abort or internal register access
// [RULE19] software write to either register of a pair clears tracking bits
// [RULE20] read returns base when bit 5 high, descriptor when low
// [RULE21] block number bits 12..6 added to the 12-bit base
// [RULE22] relocation on drives physical 17..6 from the adder
// [RULE23] relocation off passes virtual 15..6 through
// [RULE24] relocation off asserts physical 17..16 only for the top page
// [RULE25] virtual 5..0 pass straight to physical 5..0
// [RULE26] adder carry out is dropped
`default_nettype none
module page_register_file #(
  parameter int NREGS = page_regs_pkg::NUM_REGS
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // virtual address and write data from the core
  input  wire logic [15:0] VIRTUAL_ADDRESS_IN,
  input  wire logic [15:0] WRITE_DATA,
  // bus cycle timing
  input  wire logic        WORD_OUTPUT_CYCLE,
  input  wire logic        BYTE_OUTPUT_CYCLE,
  input  wire logic        CYCLE_TERMINATE,
  input  wire logic        BUST_T5,
  input  wire logic        PAUSE_T4,
  input  wire logic        WRITE_CYCLE,
  // control from the space, status and abort logic
  input  wire logic        RELOCATION_ON,
  input  wire logic [1:0]  ACTIVE_MODE,
  input  wire logic        DATA_SPACE,
  input  wire logic [2:0]  DATA_SPACE_ENABLE,
  input  wire logic        INTERNAL_REG,
  input  wire logic [2:0]  BASE_DECODE,
  input  wire logic [2:0]  DESC_DECODE,
  input  wire logic        ABORT,
  input  wire logic        TRAP_CONDITION,
  // outputs
  output logic [17:0]      PHYSICAL_ADDRESS,
  output logic [15:0]      READ_DATA,
  output logic [1:0]       BYTE_LANE_EN,
  output logic             ACCESSED_HOLD,
  output logic             WRITTEN_HOLD
);
  localparam int BW = page_regs_pkg::BASE_W;
  localparam int DW = page_regs_pkg::DESC_W;
  localparam int IW = page_regs_pkg::IDX_W;
  localparam int NM = page_regs_pkg::NUM_MODES;

  logic [IW-1:0]    reg_index;
  logic [IW-1:0]    ref_index [NM];
  logic [IW-1:0]    mode_index [NM];
  logic [NM-1:0]    mode_sel;
  logic [NM-1:0]    base_sel;
  logic [NM-1:0]    desc_sel;
  logic             out_cycle;
  logic [1:0]       nxt_lanes;
  logic             write_ok;
  logic [BW-1:0]    base_rd [NM];
  logic [DW-1:0]    desc_rd [NM];
  logic [BW-1:0]    page_base;
  logic [DW-1:0]    page_desc;
  logic [BW-1:0]    relocated;
  logic [17:0]      nxt_phys;
  logic [1:0]       io_page_flag;
  logic             tracking_we;
  logic             accessed_hold_ff;
  logic             written_hold_ff;
  logic             track_ok;
  logic [DW-1:0]    track_mask;
  logic [DW-1:0]    desc_wmask;
  logic [DW-1:0]    desc_wdata;
  logic [DW-1:0]    sw_mask;

  // index for internal register access
  assign reg_index = VIRTUAL_ADDRESS_IN[page_regs_pkg::REG_IDX_LO +: IW]; // [RULE1]

  // per-mode register selection from decodes and the active mode
  genvar m;
  generate
    for (m = 0; m < NM; m++) begin : g_mode
      logic top_bit;
      // the data space enable routes each mode independently
      assign top_bit = DATA_SPACE_ENABLE[m] ? DATA_SPACE : page_regs_pkg::SPACE_I; // [RULE4]
      assign ref_index[m] = {top_bit, // [RULE3]
        VIRTUAL_ADDRESS_IN[page_regs_pkg::VA_TOP_LO +: page_regs_pkg::VA_TOP_W]}; // [RULE2]
      assign mode_index[m] = INTERNAL_REG ? reg_index : ref_index[m];
      assign mode_sel[m] = !INTERNAL_REG && (ACTIVE_MODE == 2'(m));
      assign base_sel[m] = INTERNAL_REG ? BASE_DECODE[m] : mode_sel[m]; // [RULE9]
      assign desc_sel[m] = INTERNAL_REG ? (DESC_DECODE[m] | BASE_DECODE[m]) // [RULE11]
                                        : mode_sel[m];

      page_reg_mem #(.WIDTH(BW), .DEPTH(NREGS), .AW(IW)) u_base (
        .clk   (CLK),
        .we    (write_ok && BASE_DECODE[m]), // [RULE5]
        .wmask ({BW{1'b1}}),
        .waddr (mode_index[m]),
        .wdata (WRITE_DATA[BW-1:0]), // [RULE8]
        .raddr (mode_index[m]),
        .rdata (base_rd[m])
      );

      page_reg_mem #(.WIDTH(DW), .DEPTH(NREGS), .AW(IW)) u_desc (
        .clk   (CLK),
        .we    (desc_sel[m] && (tracking_we || (write_ok && DESC_DECODE[m]))),
        .wmask ((write_ok && DESC_DECODE[m]) ? sw_mask : track_mask),
        .waddr (mode_index[m]),
        .wdata (desc_wdata),
        .raddr (mode_index[m]),
        .rdata (desc_rd[m])
      );
    end
  endgenerate

  // write qualification; terminate always wins
  assign out_cycle = WORD_OUTPUT_CYCLE || BYTE_OUTPUT_CYCLE; // [RULE5]
  assign write_ok  = out_cycle && !CYCLE_TERMINATE && PAUSE_T4 && INTERNAL_REG; // [RULE6] [RULE8]

  always_comb begin
    nxt_lanes = 2'h0;
    if (WORD_OUTPUT_CYCLE) begin
      nxt_lanes = 2'h3; // [RULE7]
    end else if (BYTE_OUTPUT_CYCLE) begin
      nxt_lanes = VIRTUAL_ADDRESS_IN[0] ? 2'h2 : 2'h1; // [RULE7]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      BYTE_LANE_EN <= 2'h0;
    end else begin
      BYTE_LANE_EN <= nxt_lanes;
    end
  end

  // one-hot selects, so or-ing the sets acts like the shared output lines
  always_comb begin
    page_base = '0;
    page_desc = '0;
    for (int i = 0; i < NM; i++) begin
      if (base_sel[i] || desc_sel[i]) begin
        page_base = page_base | base_rd[i]; // [RULE9]
        page_desc = page_desc | desc_rd[i];
      end
    end
  end

  // descriptor field layout: length 15..8, A 7, W 6, direction 3, access 2..0
  assign sw_mask = {{page_regs_pkg::DESC_HI_W{1'b1}}, 1'b1, 1'b1, 2'h0, // [RULE10] [RULE19]
                    {page_regs_pkg::DESC_LO_W{1'b1}}};
  assign track_mask = sw_mask & ~{{page_regs_pkg::DESC_HI_W{1'b1}}, 2'h0, 2'h0,
                                  {page_regs_pkg::DESC_LO_W{1'b1}}};

  // tracking write enable during translation or register write
  assign tracking_we = PAUSE_T4 && (!INTERNAL_REG || write_ok); // [RULE13]
  assign track_ok    = !INTERNAL_REG && !ABORT; // [RULE18]

  always_comb begin
    desc_wdata = '0;
    if (write_ok) begin
      // a software write loads fields and leaves A and W cleared
      desc_wdata[DW-1 -: page_regs_pkg::DESC_HI_W] =
        WRITE_DATA[DW-1 -: page_regs_pkg::DESC_HI_W]; // [RULE12]
      desc_wdata[page_regs_pkg::DESC_LO_W-1:0] =
        WRITE_DATA[page_regs_pkg::DESC_LO_W-1:0]; // [RULE12] [RULE19]
    end else begin
      desc_wdata[page_regs_pkg::DESC_A_BIT] =
        accessed_hold_ff || (track_ok && TRAP_CONDITION); // [RULE14] [RULE17]
      desc_wdata[page_regs_pkg::DESC_W_BIT] =
        written_hold_ff || (track_ok && WRITE_CYCLE); // [RULE15] [RULE17]
    end
  end

  // hold flops catch the stored bits at bust T5
  always_ff @(posedge CLK) begin
    if (RST) begin
      accessed_hold_ff <= 1'b0;
      written_hold_ff  <= 1'b0;
    end else if (BUST_T5) begin
      accessed_hold_ff <= page_desc[page_regs_pkg::DESC_A_BIT] && track_ok; // [RULE16]
      written_hold_ff  <= page_desc[page_regs_pkg::DESC_W_BIT] && track_ok; // [RULE16]
    end
  end

  assign ACCESSED_HOLD = accessed_hold_ff;
  assign WRITTEN_HOLD  = written_hold_ff;

  // register read path
  always_ff @(posedge CLK) begin
    if (RST) begin
      READ_DATA <= '0;
    end else if (VIRTUAL_ADDRESS_IN[page_regs_pkg::SEL_BIT]) begin
      READ_DATA <= {4'h0, page_base}; // [RULE20] [RULE9]
    end else begin
      READ_DATA <= page_desc; // [RULE20]
    end
  end

  // relocation; 12-bit sum keeps carry out away
  assign relocated = page_base + {5'h0,
    VIRTUAL_ADDRESS_IN[page_regs_pkg::BLOCK_LO +: page_regs_pkg::BLOCK_W]}; // [RULE21] [RULE26]

  assign io_page_flag = (VIRTUAL_ADDRESS_IN[page_regs_pkg::VA_TOP_LO +: page_regs_pkg::VA_TOP_W]
                         == page_regs_pkg::IO_TOP) ? page_regs_pkg::IO_PAGE_HI
                                                   : page_regs_pkg::NO_PAGE_HI; // [RULE24]

  always_comb begin
    if (RELOCATION_ON) begin
      nxt_phys = {relocated, VIRTUAL_ADDRESS_IN[page_regs_pkg::LOW_W-1:0]}; // [RULE22] [RULE25]
    end else begin
      nxt_phys = {io_page_flag, // [RULE24]
                  VIRTUAL_ADDRESS_IN[page_regs_pkg::BLOCK_LO +: page_regs_pkg::PASS_W], // [RULE23]
                  VIRTUAL_ADDRESS_IN[page_regs_pkg::LOW_W-1:0]}; // [RULE25]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PHYSICAL_ADDRESS <= '0;
    end else begin
      PHYSICAL_ADDRESS <= nxt_phys;
    end
  end

  // checks
  lane_word_a: assert property (@(posedge CLK) disable iff (RST)
    WORD_OUTPUT_CYCLE |=> BYTE_LANE_EN == 2'h3) else $error("word lanes wrong"); // [RULE7]
  pass_thru_a: assert property (@(posedge CLK) disable iff (RST)
    !RELOCATION_ON |=> PHYSICAL_ADDRESS[15:0] == $past(VIRTUAL_ADDRESS_IN))
    else $error("pass through wrong"); // [RULE23]
  io_page_a: assert property (@(posedge CLK) disable iff (RST)
    (!RELOCATION_ON && VIRTUAL_ADDRESS_IN[15:13] != 3'h7) |=> PHYSICAL_ADDRESS[17:16] == 2'h0)
    else $error("io page bits wrong"); // [RULE24]
  relocation_on_sum_a: assert property (@(posedge CLK) disable iff (RST)
    RELOCATION_ON |=> PHYSICAL_ADDRESS[17:6] == $past(relocated))
    else $error("relocation wrong"); // [RULE22]
  low_bits_a: assert property (@(posedge CLK) disable iff (RST)
    1'b1 |=> PHYSICAL_ADDRESS[5:0] == $past(VIRTUAL_ADDRESS_IN[5:0]))
    else $error("low bits wrong"); // [RULE25]
  term_block_a: assert property (@(posedge CLK) disable iff (RST)
    CYCLE_TERMINATE |-> !write_ok) else $error("write under terminate"); // [RULE6]
  hold_abort_a: assert property (@(posedge CLK) disable iff (RST)
    (BUST_T5 && ABORT) |=> !ACCESSED_HOLD && !WRITTEN_HOLD)
    else $error("hold set on abort"); // [RULE18]
  // unwritten entries read as unknown, so the match must be exact
  read_sel_a: assert property (@(posedge CLK) disable iff (RST)
    !VIRTUAL_ADDRESS_IN[5] |=> READ_DATA === $past(page_desc))
    else $error("read select wrong"); // [RULE20]

  // steps of a page access and of a software write
  sequence sw_pair_write_s;
    write_ok && (|BASE_DECODE || |DESC_DECODE);
  endsequence
  sequence walk_pause_s;
    PAUSE_T4 && !INTERNAL_REG;
  endsequence
  sequence walk_trap_s;
    PAUSE_T4 && !INTERNAL_REG && !ABORT && TRAP_CONDITION;
  endsequence
  sequence walk_write_s;
    PAUSE_T4 && !INTERNAL_REG && !ABORT && WRITE_CYCLE;
  endsequence
  sequence capture_s;
    BUST_T5 && INTERNAL_REG;
  endsequence

  // lane enables follow the cycle type
  lane_hi_a: assert property (@(posedge CLK) disable iff (RST)
    (BYTE_OUTPUT_CYCLE && !WORD_OUTPUT_CYCLE && VIRTUAL_ADDRESS_IN[0]) |=> BYTE_LANE_EN == 2'h2)
    else $error("high lane wrong"); // [RULE7]
  lane_lo_a: assert property (@(posedge CLK) disable iff (RST)
    (BYTE_OUTPUT_CYCLE && !WORD_OUTPUT_CYCLE && !VIRTUAL_ADDRESS_IN[0]) |=> BYTE_LANE_EN == 2'h1)
    else $error("low lane wrong"); // [RULE7]
  lane_idle_a: assert property (@(posedge CLK) disable iff (RST)
    (!BYTE_OUTPUT_CYCLE && !WORD_OUTPUT_CYCLE) |=> BYTE_LANE_EN == 2'h0)
    else $error("idle lanes wrong"); // [RULE7]

  // software writes only in the output cycle pause slot
  wr_cond_a: assert property (@(posedge CLK) disable iff (RST)
    write_ok |-> (out_cycle && PAUSE_T4 && INTERNAL_REG))
    else $error("write outside output pause"); // [RULE5] [RULE8]
  ab_clear_a: assert property (@(posedge CLK) disable iff (RST)
    sw_pair_write_s |-> !desc_wdata[page_regs_pkg::DESC_A_BIT]
                        && !desc_wdata[page_regs_pkg::DESC_W_BIT])
    else $error("tracking not cleared"); // [RULE19]

  // tracking capture at bust T5 and write back during translation
  track_en_a: assert property (@(posedge CLK) disable iff (RST)
    walk_pause_s |-> tracking_we) else $error("tracking write missing"); // [RULE13]
  trap_set_a: assert property (@(posedge CLK) disable iff (RST)
    walk_trap_s |-> desc_wdata[page_regs_pkg::DESC_A_BIT])
    else $error("accessed not set"); // [RULE14] [RULE17]
  write_set_a: assert property (@(posedge CLK) disable iff (RST)
    walk_write_s |-> desc_wdata[page_regs_pkg::DESC_W_BIT])
    else $error("written not set"); // [RULE15] [RULE17]
  hold_int_a: assert property (@(posedge CLK) disable iff (RST)
    capture_s |=> !ACCESSED_HOLD && !WRITTEN_HOLD)
    else $error("hold set on internal access"); // [RULE18]
  hold_keep_a: assert property (@(posedge CLK) disable iff (RST)
    !BUST_T5 |=> $stable(ACCESSED_HOLD) && $stable(WRITTEN_HOLD))
    else $error("hold moved outside bust"); // [RULE16]

  // top page mapping with relocation off
  io_page_hi_a: assert property (@(posedge CLK) disable iff (RST)
    (!RELOCATION_ON && VIRTUAL_ADDRESS_IN[15:13] == page_regs_pkg::IO_TOP)
    |=> PHYSICAL_ADDRESS[17:16] == page_regs_pkg::IO_PAGE_HI)
    else $error("io page bits missing"); // [RULE24]

  // base reads are zero extended
  base_read_a: assert property (@(posedge CLK) disable iff (RST)
    VIRTUAL_ADDRESS_IN[page_regs_pkg::SEL_BIT] |=> READ_DATA[15:12] == 4'h0)
    else $error("base read not zero extended"); // [RULE9]

  // selects stay one-hot as long as the decodes are
  base_one_a: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(base_sel)) else $error("two base sets on"); // [RULE9]
  desc_one_a: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(desc_sel)) else $error("two descriptor sets on"); // [RULE11]

  // register index sources
  reg_index_a: assert property (@(posedge CLK) disable iff (RST)
    INTERNAL_REG |-> mode_index[0] == VIRTUAL_ADDRESS_IN[4:1])
    else $error("internal index wrong"); // [RULE1]
  ref_index_a: assert property (@(posedge CLK) disable iff (RST)
    !INTERNAL_REG |-> mode_index[0][2:0] == VIRTUAL_ADDRESS_IN[15:13])
    else $error("reference index wrong"); // [RULE2]
  space_off_a: assert property (@(posedge CLK) disable iff (RST)
    (!INTERNAL_REG && !DATA_SPACE_ENABLE[0]) |-> !mode_index[0][3])
    else $error("data space used while off"); // [RULE3] [RULE4]
endmodule
`default_nettype wire

// *** core/page_regs_pkg.sv ***
// constants for the page register file and relocation path
`default_nettype none
package page_regs_pkg;
  localparam int VA_W        = 16;
  localparam int PA_W        = 18;
  localparam int BASE_W      = 12;
  localparam int DESC_W      = 16;
  localparam int IDX_W       = 4;
  localparam int NUM_MODES   = 3;
  localparam int NUM_REGS    = 16;
  localparam int REG_IDX_LO  = 1;
  localparam int VA_TOP_LO   = 13;
  localparam int VA_TOP_W    = 3;
  localparam int SEL_BIT     = 5;
  localparam int BLOCK_LO    = 6;
  localparam int BLOCK_W     = 7;
  localparam int LOW_W       = 6;
  localparam int HI_LO       = 16;
  localparam int DESC_HI_LO  = 8;
  localparam int DESC_HI_W   = 8;
  localparam int DESC_LO_W   = 4;
  localparam int DESC_A_BIT  = 7;
  localparam int DESC_W_BIT  = 6;
  localparam int PASS_W      = 10;
  localparam logic [1:0]        IO_PAGE_HI = 2'h3;
  localparam logic [1:0]        NO_PAGE_HI = 2'h0;
  localparam logic [VA_TOP_W-1:0] IO_TOP   = 3'h7;
  localparam logic              SPACE_I    = 1'h0;
  localparam logic              SPACE_D    = 1'h1;
  localparam logic [1:0]        MODE_KERNEL = 2'h0;
  localparam logic [1:0]        MODE_SUPER  = 2'h1;
  localparam logic [1:0]        MODE_USER   = 2'h2;
endpackage
`default_nettype wire

// *** core/page_reg_mem.sv ***
// one register set: sixteen entries with registered read data and write port
`default_nettype none
module page_reg_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             we,
  input  wire logic [WIDTH-1:0] wmask,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_ff [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_ff[waddr] <= (mem_ff[waddr] & ~wmask) | (wdata & wmask);
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem_ff[raddr];
  end
endmodule
`default_nettype wire

// *** sim/core_model.sv ***
// processor core model: register writes, reads and translated accesses
`default_nettype none
module core_model (
  // clock
  input  wire logic        clk,
  // address, data and cycle timing
  output logic      [15:0] va,
  output logic      [15:0] wd,
  output logic             wo,
  output logic             bo,
  output logic             term,
  output logic             t5,
  output logic             t4,
  output logic             wcyc,
  // space, status and abort control
  output logic             rel,
  output logic      [1:0]  mode,
  output logic             dsp,
  output logic      [2:0]  dse,
  output logic             intreg,
  output logic      [2:0]  bdec,
  output logic      [2:0]  ddec,
  output logic             abort,
  output logic             trap
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {va, wd, wo, bo, term, t5, t4, wcyc, rel, mode, dsp, dse} = '0;
    {intreg, bdec, ddec, abort, trap} = '0;
  end
  // bit 5 picks the base or the descriptor decode of mode m
  task automatic sel(input logic [1:0] m, input logic [15:0] a);
    intreg = 1'b1;
    va = a;
    bdec = a[5] ? 3'h1 << m : 3'h0;
    ddec = a[5] ? 3'h0 : 3'h1 << m;
  endtask
  task automatic wr(input logic [1:0] m, input logic [15:0] a, d, input logic b, k);
    @(negedge clk);
    sel(m, a);
    wd = d;
    wo = !b;
    bo = b;
    term = k;
    @(negedge clk);
    t4 = 1'b1;
    @(negedge clk);
    {t4, wo, bo, term, intreg, bdec, ddec} = '0;
    // released data is inverted so a stale value cannot pass
    wd = ~d;
  endtask
  // read data lags the address by two edges
  task automatic rd(input logic [1:0] m, input logic [15:0] a);
    @(negedge clk);
    sel(m, a);
    repeat (2) @(negedge clk);
  endtask
  // address held stable before the bust timing pulse
  task automatic bust(input logic [1:0] m, input logic [15:0] a, input logic d, r,
                      input logic [2:0] e);
    @(negedge clk);
    {intreg, bdec, ddec} = '0;
    {mode, va, dsp, rel, dse} = {m, a, d, r, e};
    repeat (2) @(negedge clk);
    t5 = 1'b1;
    @(negedge clk);
    t5 = 1'b0;
  endtask
  task automatic pause(input logic w, tr);
    {wcyc, trap, t4} = {w, tr, 1'b1};
    @(negedge clk);
    {wcyc, trap, t4} = '0;
  endtask
endmodule
`default_nettype wire

// *** sim/test_page_register_file.sv ***
// self-checking bench for the page register file
`default_nettype none
module test_page_register_file;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wo, bo, term, t5, t4, wcyc, rel, dsp, intreg, abort, trap, ah, wh;
  logic [15:0] va, wd, rdat;
  logic [1:0]  mode, lanes;
  logic [2:0]  dse, bdec, ddec;
  logic [17:0] pa;
  int          failures, samples_checked, cycles;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
  localparam logic [1:0] K = page_regs_pkg::MODE_KERNEL;
  core_model core (.clk(clk), .va(va), .wd(wd), .wo(wo), .bo(bo), .term(term), .t5(t5),
    .t4(t4), .wcyc(wcyc), .rel(rel), .mode(mode), .dsp(dsp), .dse(dse), .intreg(intreg),
    .bdec(bdec), .ddec(ddec), .abort(abort), .trap(trap));
  page_register_file uut (.CLK(clk), .RST(rst), .VIRTUAL_ADDRESS_IN(va), .WRITE_DATA(wd),
    .WORD_OUTPUT_CYCLE(wo), .BYTE_OUTPUT_CYCLE(bo), .CYCLE_TERMINATE(term), .BUST_T5(t5),
    .PAUSE_T4(t4), .WRITE_CYCLE(wcyc), .RELOCATION_ON(rel), .ACTIVE_MODE(mode),
    .DATA_SPACE(dsp), .DATA_SPACE_ENABLE(dse), .INTERNAL_REG(intreg), .BASE_DECODE(bdec),
    .DESC_DECODE(ddec), .ABORT(abort), .TRAP_CONDITION(trap), .PHYSICAL_ADDRESS(pa),
    .READ_DATA(rdat), .BYTE_LANE_EN(lanes), .ACCESSED_HOLD(ah), .WRITTEN_HOLD(wh));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      conclude();
    end
  end
  task automatic t_base();
    core.wr(K, 16'h0026, 16'hfabc, 1'b0, 1'b0);
    `CHK(lanes, 2'h3)
    core.wr(page_regs_pkg::MODE_SUPER, 16'h0027, 16'h0123, 1'b1, 1'b0);
    `CHK(lanes, 2'h2)
    core.rd(K, 16'h0026);
    `CHK(rdat, 16'h0abc)
    core.rd(page_regs_pkg::MODE_SUPER, 16'h0026);
    `CHK(rdat, 16'h0123)
    $display("t_base done");
  endtask
  task automatic t_term();
    core.wr(K, 16'h0026, 16'h0777, 1'b0, 1'b1);
    core.rd(K, 16'h0026);
    `CHK(rdat, 16'h0abc)
    $display("t_term done");
  endtask
  task automatic t_desc();
    core.wr(K, 16'h0006, 16'h7f3d, 1'b0, 1'b0);
    core.rd(K, 16'h0006);
    `CHK({rdat[15:6], rdat[3:0]}, 14'h1fcd)
    $display("t_desc done");
  endtask
  // base plus block number 0x3f of address 0x6fc5, low six bits passed
  task automatic t_relocation_on();
    core.wr(K, 16'h0036, 16'h0ffe, 1'b0, 1'b0);
    core.bust(K, 16'h6fc5, page_regs_pkg::SPACE_I, 1'b1, 3'h0);
    `CHK(pa, {12'habc + 12'h03f, 6'h05})
    core.pause(1'b0, 1'b0);
    core.bust(K, 16'h6fc5, page_regs_pkg::SPACE_D, 1'b1, 3'h1);
    `CHK(pa, {12'h03d, 6'h05})
    core.pause(1'b0, 1'b0);
    core.bust(K, 16'h6fc5, page_regs_pkg::SPACE_D, 1'b1, 3'h6);
    `CHK(pa, {12'habc + 12'h03f, 6'h05})
    core.pause(1'b0, 1'b0);
    $display("t_relocation_on done");
  endtask
  task automatic t_off();
    core.bust(K, 16'he123, 1'b0, 1'b0, 3'h0);
    `CHK(pa, 18'h3e123)
    core.pause(1'b0, 1'b0);
    core.bust(K, 16'hc123, 1'b0, 1'b0, 3'h0);
    `CHK(pa, 18'h0c123)
    core.pause(1'b0, 1'b0);
    $display("t_off done");
  endtask
  task automatic t_track();
    core.bust(K, 16'h6fc5, 1'b0, 1'b1, 3'h0);
    `CHK({ah, wh}, 2'h0)
    core.pause(1'b1, 1'b1);
    core.bust(K, 16'h6fc5, 1'b0, 1'b1, 3'h0);
    `CHK({ah, wh}, 2'h3)
    core.pause(1'b0, 1'b0);
    core.rd(K, 16'h0006);
    `CHK(rdat[7:6], 2'h3)
    core.wr(K, 16'h0026, 16'h0abc, 1'b0, 1'b0);
    core.rd(K, 16'h0006);
    `CHK(rdat[7:6], 2'h0)
    $display("t_track done");
  endtask
  // low byte write enables only the low lane; an aborted access must not mark the page
  task automatic t_abort();
    core.wr(K, 16'h0026, 16'h0abc, 1'b1, 1'b0);
    `CHK(lanes, 2'h1)
    core.abort = 1'b1;
    core.bust(K, 16'h6fc5, 1'b0, 1'b1, 3'h0);
    `CHK({ah, wh}, 2'h0)
    core.pause(1'b1, 1'b1);
    core.abort = 1'b0;
    core.bust(K, 16'h6fc5, 1'b0, 1'b1, 3'h0);
    `CHK({ah, wh}, 2'h0)
    core.pause(1'b0, 1'b0);
    $display("t_abort done");
  endtask
  initial begin
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_base();
    t_term();
    t_desc();
    t_relocation_on();
    t_off();
    t_track();
    t_abort();
    conclude();
  end
endmodule
`default_nettype wire
